// >>> swwr_top.sv
/*
  Sleep, wakeup, watchdog and reset sequencer for a small controller.
  Assumes the CPU issues one-cycle command strobes on i_ref_clk, interrupt
  requests are levels on i_ref_clk held until serviced, and port A pins,
  the 32 kHz clock and the external reset pin are asynchronous.
*/
`timescale 1ns/1ps
module swwr_top #(
  parameter int unsigned WDT_LIMIT   = swwr_pkg::WDT_CYCLES,
  parameter int unsigned PLL_SETTLE  = swwr_pkg::PLL_CYCLES
) (
  // Clock and power-on reset
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_resetn,
  // Pins
  input  wire logic                          i_external_reset_n,
  input  wire logic [swwr_pkg::PORT_W-1:0]   i_port_a,
  input  wire logic                          i_clk_32k,
  // CPU side
  input  wire swwr_pkg::swwr_cmd_s           i_cmd,
  input  wire swwr_pkg::swwr_wake_s          i_wake,
  input  wire logic                          i_key_wake_en,
  input  wire logic                          i_tick_wake_en,
  // Clock and reset control
  output logic                               o_pll_en,
  output logic                               o_cpu_clk_en,
  output logic                               o_sleep,
  output logic                               o_sys_reset_n,
  // Status toward the CPU
  output logic                               o_wake_irq,
  output logic [swwr_pkg::CAUSE_W-1:0]       o_wake_cause,
  output logic                               o_soft_reset_flag,
  output logic [swwr_pkg::PORT_W-1:0]        o_port_a_input_latch
);
  import swwr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic              ext_rst_n_s;
  logic [PORT_W-1:0] port_a_s;
  logic              clk_32k_s;
  logic              clk_32k_d;

  swwr_sync #(.W(1), .INIT(1'b1)) u_sync_rst (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_d       (i_external_reset_n),
    .o_q       (ext_rst_n_s)
  );

  swwr_sync #(.W(PORT_W), .INIT('0)) u_sync_port (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_d       (i_port_a),
    .o_q       (port_a_s)
  );

  swwr_sync #(.W(1), .INIT(1'b0)) u_sync_tick (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_d       (i_clk_32k),
    .o_q       (clk_32k_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command decode.
  function automatic logic key_hit(input swwr_cmd_s c, input swwr_cmd_e t);
    key_hit = c.valid && (c.target == t) && (c.data == UNLOCK_KEY);
  endfunction

  swwr_state_e        st;
  swwr_state_e        next_st;
  logic [RST_W-1:0]   rst_cnt;
  logic [WDT_W-1:0]   wdt_cnt;
  logic [PLL_W-1:0]   pll_cnt;

  wire in_reset   = (rst_cnt != '0);
  wire cpu_live   = (st == SWWR_RUN) && !in_reset;
  wire sleep_hit  = key_hit(i_cmd, SWWR_CMD_SLEEP) && cpu_live;
  wire soft_hit   = key_hit(i_cmd, SWWR_CMD_SOFT_RESET) && cpu_live;
  wire wdt_clr    = i_cmd.valid && (i_cmd.target == SWWR_CMD_WDT_CLEAR) && cpu_live;
  wire pa_read    = i_cmd.valid && (i_cmd.target == SWWR_CMD_PORT_A_READ) && cpu_live;
  wire flag_clr   = i_cmd.valid && (i_cmd.target == SWWR_CMD_FLAG_CLEAR) && cpu_live;
  wire wdt_ovf    = cpu_live && (wdt_cnt == WDT_W'(WDT_LIMIT - 1)) && !wdt_clr;
  wire pin_low    = !ext_rst_n_s;
  wire rst_req    = pin_low || wdt_ovf || soft_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Wakeup sources.
  wire tick_rise  = clk_32k_s && !clk_32k_d;
  wire key_change = i_key_wake_en && (port_a_s != o_port_a_input_latch);
  wire [CAUSE_W-1:0] wake_vec = {
    i_tick_wake_en && tick_rise,
    key_change,
    i_wake.external_interrupt_two,
    i_wake.external_interrupt_one,
    i_wake.spi,
    i_wake.timer_c,
    i_wake.timer_b,
    i_wake.timer_a,
    i_wake.fast_interrupt_request
  };
  wire wake_any   = (wake_vec != '0);

  ////////////////////////////////////////////////////////////////////////////
  // Sleep sequencer. The CPU clock is gated one cycle before the PLL so the
  // core never sees a truncated clock pulse.
  always_comb begin
    next_st = st;
    case (st)
      SWWR_RUN: begin
        if (sleep_hit) begin
          next_st = SWWR_GATE;
        end
      end
      SWWR_GATE: begin
        next_st = SWWR_SLEEP;
      end
      SWWR_SLEEP: begin
        if (wake_any) begin
          next_st = SWWR_START;
        end
      end
      SWWR_START: begin
        if (pll_cnt == PLL_W'(1)) begin
          next_st = SWWR_RUN;
        end
      end
      default: begin
        next_st = SWWR_RUN;
      end
    endcase
    if (rst_req || in_reset) begin
      next_st = SWWR_RUN;
    end
  end

  wire [RST_W-1:0] next_rst_cnt = rst_req ? RST_W'(RST_CYCLES) :
                                  in_reset ? rst_cnt - RST_W'(1) : rst_cnt;
  wire [PLL_W-1:0] next_pll_cnt = (st == SWWR_SLEEP) ? PLL_W'(PLL_SETTLE) :
                                  (st == SWWR_START && pll_cnt != '0) ? pll_cnt - PLL_W'(1) : pll_cnt;
  wire [WDT_W-1:0] next_wdt_cnt = (rst_req || in_reset || wdt_clr) ? '0 :
                                  cpu_live ? wdt_cnt + WDT_W'(1) : wdt_cnt;
  wire next_flag = soft_hit || (o_soft_reset_flag && !flag_clr);
  wire next_wake_irq = (st == SWWR_START) && (next_st == SWWR_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // The watchdog is held while the core clock is stopped, since software
  // cannot service it in sleep.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st        <= SWWR_RUN;
      rst_cnt   <= '0;
      wdt_cnt   <= '0;
      pll_cnt   <= '0;
      clk_32k_d <= 1'b0;
    end else begin
      st        <= next_st;
      rst_cnt   <= next_rst_cnt;
      wdt_cnt   <= next_wdt_cnt;
      pll_cnt   <= next_pll_cnt;
      clk_32k_d <= clk_32k_s;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pll_en             <= 1'b1;
      o_cpu_clk_en         <= 1'b1;
      o_sleep              <= 1'b0;
      o_sys_reset_n        <= 1'b1;
      o_wake_irq           <= 1'b0;
      o_wake_cause         <= '0;
      o_soft_reset_flag    <= 1'b0;
      o_port_a_input_latch <= '0;
    end else begin
      o_pll_en             <= (next_st == SWWR_RUN) || (next_st == SWWR_START) || (next_st == SWWR_GATE);
      o_cpu_clk_en         <= (next_st == SWWR_RUN);
      o_sleep              <= (next_st == SWWR_SLEEP) || (next_st == SWWR_GATE);
      o_sys_reset_n        <= (next_rst_cnt == '0);
      o_wake_irq           <= next_wake_irq;
      o_soft_reset_flag    <= next_flag;
      if (st == SWWR_SLEEP && wake_any) begin
        o_wake_cause       <= wake_vec;
      end
      if (pa_read) begin
        o_port_a_input_latch <= port_a_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_run_until_cmd;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    (st == SWWR_RUN) && !sleep_hit |=> (st == SWWR_RUN);
  endproperty
  a_run_until_cmd: assert property (p_run_until_cmd) else $error("sleep without command");

  property p_sleep_entry;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    sleep_hit |=> !o_cpu_clk_en && o_pll_en ##1 !o_pll_en && o_sleep;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry sequence wrong");

  property p_sleep_hold;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    (st == SWWR_SLEEP) && !wake_any && !rst_req |=> (st == SWWR_SLEEP) && !o_pll_en;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("left sleep without wakeup");

  property p_wake_pll;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    (st == SWWR_SLEEP) && wake_any |=> o_pll_en && !o_cpu_clk_en;
  endproperty
  a_wake_pll: assert property (p_wake_pll) else $error("wakeup did not restart pll");

  property p_wake_finish;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    (st == SWWR_START) && (pll_cnt == PLL_W'(1)) && !rst_req && !in_reset
      |=> o_wake_irq && o_cpu_clk_en ##1 !o_wake_irq;
  endproperty
  a_wake_finish: assert property (p_wake_finish) else $error("wakeup completion missing");

  property p_wake_cause;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    (st == SWWR_SLEEP) && wake_any |=> (o_wake_cause == $past(wake_vec));
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake cause not captured");

  property p_wdt_count;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    cpu_live && !wdt_clr && !rst_req |=> (wdt_cnt == $past(wdt_cnt) + WDT_W'(1));
  endproperty
  a_wdt_count: assert property (p_wdt_count) else $error("watchdog not counting");

  property p_wdt_reset;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    wdt_ovf |=> !o_sys_reset_n [*8];
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("overflow gave no reset");

  property p_wdt_clear;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    wdt_clr |=> (wdt_cnt == '0) && (o_sys_reset_n == !$past(pin_low));
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear ignored");

  property p_reset_state;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    !o_sys_reset_n |-> (st == SWWR_RUN) && (wdt_cnt == '0);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset not initial state");

  property p_soft_reset;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    soft_hit |=> !o_sys_reset_n && o_soft_reset_flag;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset or flag missing");

  property p_key_wake;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    (st == SWWR_SLEEP) && key_change && !rst_req |=> o_pll_en ##1 (st == SWWR_START);
  endproperty
  a_key_wake: assert property (p_key_wake) else $error("key change did not wake");

  property p_sleep_gated;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    o_sleep |-> !o_cpu_clk_en && o_sys_reset_n;
  endproperty
  a_sleep_gated: assert property (p_sleep_gated) else $error("core clocked in sleep");

  property p_resume;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    (st == SWWR_START) && !rst_req && !in_reset |=> o_sys_reset_n;
  endproperty
  a_resume: assert property (p_resume) else $error("wakeup reset the core");

  property p_bad_key;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    cpu_live && i_cmd.valid && (i_cmd.data != UNLOCK_KEY) && !pin_low && !wdt_ovf
      |=> (st == SWWR_RUN) && o_sys_reset_n;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("non-key write took effect");

endmodule

// >>> swwr_pkg.sv
/*
  Shared constants, command encodings and carrier structs for the sleep,
  wakeup, watchdog and reset sequencer.
  Assumes a single 25 MHz reference clock that keeps running in sleep.
*/
package swwr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam logic [15:0] UNLOCK_KEY    = 16'h5555;

  // Least times round up to whole cycles.
  localparam int unsigned RST_PULSE_NS  = 1000;
  localparam int unsigned RST_CYCLES    = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PLL_SETTLE_NS = 100_000;
  localparam int unsigned PLL_CYCLES    = (PLL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest time rounds down to whole cycles.
  localparam int unsigned WDT_PERIOD_NS = 750_000_000;
  localparam int unsigned WDT_CYCLES    = WDT_PERIOD_NS / CLK_PERIOD_NS;

  localparam int unsigned RST_W  = 5;
  localparam int unsigned PLL_W  = 12;
  localparam int unsigned WDT_W  = 25;
  localparam int unsigned PORT_W = 16;
  localparam int unsigned CAUSE_W = 9;

  // Bit positions inside the wakeup cause vector.
  localparam int unsigned CAUSE_FIQ  = 0;
  localparam int unsigned CAUSE_TMA  = 1;
  localparam int unsigned CAUSE_TMB  = 2;
  localparam int unsigned CAUSE_TMC  = 3;
  localparam int unsigned CAUSE_SPI  = 4;
  localparam int unsigned CAUSE_EXTERNAL_INTERRUPT_ONE = 5;
  localparam int unsigned CAUSE_EXTERNAL_INTERRUPT_TWO = 6;
  localparam int unsigned CAUSE_KEY  = 7;
  localparam int unsigned CAUSE_TICK = 8;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    SWWR_CMD_NONE,
    SWWR_CMD_SLEEP,
    SWWR_CMD_SOFT_RESET,
    SWWR_CMD_WDT_CLEAR,
    SWWR_CMD_PORT_A_READ,
    SWWR_CMD_FLAG_CLEAR
  } swwr_cmd_e;

  typedef struct packed {
    logic        valid;
    swwr_cmd_e   target;
    logic [15:0] data;
  } swwr_cmd_s;

  typedef struct packed {
    logic fast_interrupt_request;
    logic timer_a;
    logic timer_b;
    logic timer_c;
    logic spi;
    logic external_interrupt_one;
    logic external_interrupt_two;
  } swwr_wake_s;

  typedef enum logic [1:0] {
    SWWR_RUN,
    SWWR_GATE,
    SWWR_SLEEP,
    SWWR_START
  } swwr_state_e;

endpackage

// >>> swwr_sync.sv
/*
  Three-stage synchroniser for pin inputs; the output changes only once the
  second and third stages agree.
  Assumes inputs are asynchronous to i_ref_clk.
*/
`timescale 1ns/1ps
module swwr_sync #(
  parameter int unsigned           W    = 1,
  parameter logic [W-1:0]          INIT = '0
) (
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_resetn,
  // Data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  wire  [W-1:0] agree = ~(stage2 ^ stage3);

  // A lone glitch reaching stage2 is filtered because stage3 must match it.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
      o_q    <= INIT;
    end else begin
      stage1 <= i_d;
      stage2 <= stage1;
      stage3 <= stage2;
      o_q    <= (agree & stage3) | (~agree & o_q);
    end
  end

endmodule

// >>> swwr_cpu_model.sv
/*
  Behavioural model of the CPU and the interrupt sources facing the sequencer.
  Assumes the bench asks for commands and wake sources by one-cycle pulses.
*/
`timescale 1ns/1ps
module swwr_cpu_model (
  // Clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_resetn,
  // Bench requests
  input  wire logic                 i_req,
  input  wire swwr_pkg::swwr_cmd_s  i_req_cmd,
  input  wire logic [6:0]           i_wake_req,
  input  wire logic                 i_auto_clear,
  // Sequencer side
  input  wire logic                 i_wake_irq,
  output swwr_pkg::swwr_cmd_s       o_cmd,
  output swwr_pkg::swwr_wake_s      o_wake
);
  import swwr_pkg::*;

  logic [4:0] kick_cnt;
  logic       pend;

  ////////////////////////////////////////////////////////////////////////////
  // A bench request takes the slot, so a clear may slip one cycle but never a whole period.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      kick_cnt <= '0;
      pend     <= 1'b0;
      o_cmd    <= '0;
      o_wake   <= '0;
    end else begin
      kick_cnt <= kick_cnt + 5'h1;
      pend     <= i_req && i_auto_clear && (kick_cnt == 5'h1F || pend);
      if (i_req) begin
        o_cmd <= i_req_cmd;
      end else if (i_auto_clear && (kick_cnt == 5'h1F || pend)) begin
        o_cmd <= '{valid: 1'b1, target: SWWR_CMD_WDT_CLEAR, data: 16'h0000};
      end else begin
        o_cmd <= '0;
      end
      // Requests stay up until the wakeup interrupt services them.
      o_wake <= i_wake_irq ? '0 : (o_wake | i_wake_req);
    end
  end
endmodule

// >>> tb_top.sv
/*
  Self-checking bench for the sleep, wakeup, watchdog and reset sequencer.
  Assumes short watchdog and settle parameters and a CPU model on the far side.
*/
`timescale 1ns/1ps
module tb_top;
  import swwr_pkg::*;

  localparam int unsigned WDT_LIM = 64;
  localparam int unsigned PLL_SET = 4;

  logic        clk, rstn, ext_n, clk32, key_en, tick_en, req, auto_clr;
  logic        pll_en, cpu_en, sleep, sys_rn, irq, flag;
  logic [15:0] port_a, latch, exp_latch, d;
  logic [6:0]  wake_req;
  logic [8:0]  cause;
  logic [31:0] seed;
  swwr_cmd_s   req_cmd, cmd;
  swwr_wake_s  wake;
  int          fail_count, tests_run, n, exp_flag;
  int unsigned cause_q[$];

  swwr_top #(.WDT_LIMIT(WDT_LIM), .PLL_SETTLE(PLL_SET)) dut (
    .i_ref_clk(clk), .i_resetn(rstn), .i_external_reset_n(ext_n), .i_port_a(port_a),
    .i_clk_32k(clk32), .i_cmd(cmd), .i_wake(wake), .i_key_wake_en(key_en),
    .i_tick_wake_en(tick_en), .o_pll_en(pll_en), .o_cpu_clk_en(cpu_en), .o_sleep(sleep),
    .o_sys_reset_n(sys_rn), .o_wake_irq(irq), .o_wake_cause(cause),
    .o_soft_reset_flag(flag), .o_port_a_input_latch(latch));

  swwr_cpu_model u_cpu (
    .i_ref_clk(clk), .i_resetn(rstn), .i_req(req), .i_req_cmd(req_cmd), .i_wake_req(wake_req),
    .i_auto_clear(auto_clr), .i_wake_irq(irq), .o_cmd(cmd), .o_wake(wake));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic complete_run();
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The model holds the request one cycle; the sequencer takes it on the edge after.
  task automatic send(input swwr_cmd_e t, input logic [15:0] v);
    req_cmd <= '{valid: 1'b1, target: t, data: v};
    req     <= 1'b1;
    tick(1);
    req     <= 1'b0;
    tick(1);
  endtask

  task automatic low_len();
    n = 0;
    while (sys_rn !== 1'b1 && n < 200) begin
      n++;
      tick(1);
    end
  endtask

  task automatic high_len(input int lim);
    n = 0;
    while (sys_rn === 1'b1 && n < lim) begin
      n++;
      tick(1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    #(40 * 30000);
    fail_count++;
    complete_run();
  end

  initial begin
    rstn = 1'b0; ext_n = 1'b1; clk32 = 1'b0; key_en = 1'b0; tick_en = 1'b0; req = 1'b0;
    auto_clr = 1'b0; port_a = 16'h0000; wake_req = '0; req_cmd = '0;
    fail_count = 0; tests_run = 0; exp_flag = 0; seed = 32'd76599;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("run_after_reset", 3'b110, {pll_en, cpu_en, sleep});
    high_len(WDT_LIM + 10);
    chk("wdt_from_reset", 1, 32'(n >= WDT_LIM && n <= WDT_LIM + 2));
    low_len();
    chk("wdt_reset_width", RST_CYCLES, n);
    tick(3);
    send(SWWR_CMD_WDT_CLEAR, 16'h0000);
    high_len(WDT_LIM + 10);
    chk("wdt_overflow", WDT_LIM, n);
    low_len();
    chk("wdt_reset_width", RST_CYCLES, n);
    chk("flag_after_wdt", exp_flag, flag);
    auto_clr <= 1'b1;
    high_len(3 * WDT_LIM);
    chk("run_with_clears", 3 * WDT_LIM, n);
    chk("no_sleep_unasked", 0, sleep);
    repeat (4) begin
      seed = xs(seed);
      d = (seed[15:0] == UNLOCK_KEY) ? 16'h5554 : seed[15:0];
      send(SWWR_CMD_SLEEP, d);
      send(SWWR_CMD_SOFT_RESET, d);
      tick(1);
      chk("bad_key_state", 3'b011, {sleep, sys_rn, cpu_en});
      chk("bad_key_flag", exp_flag, flag);
    end
    send(SWWR_CMD_SOFT_RESET, UNLOCK_KEY);
    exp_flag = 1;
    chk("soft_flag", exp_flag, flag);
    low_len();
    chk("soft_reset_width", RST_CYCLES, n);
    ext_n <= 1'b0;
    tick(10);
    chk("pin_reset", 0, sys_rn);
    ext_n <= 1'b1;
    low_len();
    chk("pin_reset_width", 1, 32'(n >= RST_CYCLES && n <= RST_CYCLES + 6));
    chk("flag_after_pin", exp_flag, flag);
    send(SWWR_CMD_FLAG_CLEAR, 16'h0000);
    exp_flag = 0;
    chk("flag_cleared", exp_flag, flag);
    for (int i = 0; i < 9; i++) begin
      seed = xs(seed);
      exp_latch = seed[15:0];
      port_a <= exp_latch;
      tick(5);
      send(SWWR_CMD_PORT_A_READ, 16'h0000);
      chk("port_a_latch", exp_latch, latch);
      key_en <= (i == CAUSE_KEY);
      tick_en <= (i == CAUSE_TICK);
      send(SWWR_CMD_SLEEP, UNLOCK_KEY);
      chk("sleep_entry", 2'b01, {cpu_en, sleep});
      tick(1);
      chk("pll_off", 0, pll_en);
      if (i != CAUSE_KEY) begin
        port_a <= ~exp_latch;
      end
      tick(4);
      chk("latch_held", exp_latch, latch);
      chk("still_asleep", 2'b01, {pll_en, sleep});
      if (i == CAUSE_KEY) begin
        port_a <= exp_latch ^ (seed[31:16] | 16'h0001);
      end else if (i == CAUSE_TICK) begin
        clk32 <= 1'b1;
      end else begin
        wake_req <= 7'h40 >> i;
      end
      cause_q.push_back(32'(1) << i);
      tick(1);
      wake_req <= '0;
      n = 0;
      while (pll_en !== 1'b1 && n < 20) begin
        n++;
        tick(1);
      end
      chk("pll_on", 1, pll_en);
      chk("wake_cause", cause_q.pop_front(), cause);
      n = 0;
      while (irq !== 1'b1 && n < PLL_SET + 10) begin
        n++;
        tick(1);
      end
      chk("wake_irq", 1, irq);
      chk("cpu_clk_on", 1, cpu_en);
      chk("resumed", {1'b1, 1'(exp_flag)}, {sys_rn, flag});
      key_en <= 1'b0;
      tick_en <= 1'b0;
      clk32 <= 1'b0;
      tick(2);
    end
    complete_run();
  end
endmodule
